// ---- voice_call_cfg.svh ----
//
// Purpose: Constants for the telephone voice call controller
// Assumes: 40 MHz system clock, one second timebase
// Notes: Interval times in seconds, clock times in ns; cycle counts derived below
//
// Contract
// RQ1 - Sections zero to three are system prompts; preset message is never below four.
// RQ2 - Section zero plays only on an incoming call to this module.
// RQ3 - Section one plays only after a correct password.
// RQ4 - Section two plays whenever a password fails; the code plays it only on the first two failures, since the third hangs up.
// RQ5 - Section three plays on every call this device placed.
// RQ6 - Incoming call: answer, play section zero, wait for password.
// RQ7 - Incoming wrong password: play section two, then repeat section zero.
// RQ8 - Outgoing alarm call plays preset message with section three.
// RQ9 - Outgoing correct password: section one, then preset repeats, control enabled.
// RQ10 - Outgoing wrong password: section two, then repeat section three and preset.
// RQ11 - Outgoing call unanswered or no password in 40 s: abort, stop playback.
// RQ12 - After such an abort, redial every 20 s.
// RQ13 - Star precedes a password; star stops current playback at once; the code ignores star while section one or two plays.
// RQ14 - Caller keys four digits within nine seconds after playback stops.
// RQ15 - Digits late: replay prompt, demand a new star.
// RQ16 - Two wrong passwords tolerated; third wrong hangs up and stops playback.
// RQ17 - After that hang-up, keep calling every 20 s while alarm persists.
// RQ18 - Alarm voice repeats every 20 s until user program stops it.
// RQ19 - Two pound keys end the session; line released.
// RQ20 - Call ends after 30 s without caller activity.
// RQ21 - Reset: idle, line released, no playback, counters and timers cleared.
//
`ifndef VOICE_CALL_CFG_SVH
`define VOICE_CALL_CFG_SVH

// ------------------------------------------------------------
// Clock and timebase
// ------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define ONE_SEC_NS 1000000000
`define TICK_CYC (`ONE_SEC_NS / `CLK_PERIOD_NS)

// ------------------------------------------------------------
// Interval timers, in seconds
// ------------------------------------------------------------
`define NOPASS_S 6'h28
`define REDIAL_S 6'h14
`define DIGIT_S 6'h09
`define INACT_S 6'h1E

// ------------------------------------------------------------
// Voice sections
// ------------------------------------------------------------
`define SEC_STATUS 7'h00
`define SEC_PASS_OK 7'h01
`define SEC_PASS_BAD 7'h02
`define SEC_ALARM 7'h03
`define SEC_USER_MIN 7'h04

// ------------------------------------------------------------
// Keypad
// ------------------------------------------------------------
`define KEY_STAR 4'hA
`define KEY_POUND 4'hB
`define LAST_DIGIT 3'h3
`define WRONG_LIMIT 2'h2

`endif

// ---- voice_call_pkg.sv ----
//
// Purpose: Types for the telephone voice call controller
// Assumes: Nothing beyond SystemVerilog
// Notes: States are one-hot
//
package voice_call_pkg;

  typedef enum logic [6:0] {
    S_IDLE   = 7'h01,
    S_DIAL   = 7'h02,
    S_PROMPT = 7'h04,
    S_DIGITS = 7'h08,
    S_ACK    = 7'h10,
    S_NAK    = 7'h20,
    S_CTRL   = 7'h40
  } state_t;

  typedef logic [6:0] section_t;
  typedef logic [3:0] key_t;
  typedef logic [5:0] secs_t;

endpackage

// ---- voice_call_ctrl.sv ----
//
// Purpose: Call sequencer: answer, alarm dial, password check, prompts
// Assumes: Keypad and line events are synchronous one-cycle pulses
// Notes: Timers count whole seconds of a shared prescaler
//
`timescale 1ns/1ps
`include "voice_call_cfg.svh"

module voice_call_ctrl
#(
  parameter int TICK_CYCLES = `TICK_CYC
)
(
  input wire logic I_CLK,
  input wire logic I_RST,
  input wire logic I_RING,
  input wire logic I_ANSWERED,
  input wire logic I_KEY_VALID,
  input wire voice_call_pkg::key_t I_KEY_CODE,
  input wire logic [15:0] I_PASSWORD,
  input wire voice_call_pkg::section_t I_PRESET_SEC,
  input wire logic I_ALARM,
  input wire logic I_ALARM_STOP,
  input wire logic I_PLAY_DONE,
  output logic O_OFF_HOOK,
  output logic O_DIAL,
  output logic O_PLAY,
  output voice_call_pkg::section_t O_SECTION,
  output logic O_CTRL_EN
);
  import voice_call_pkg::*;

  localparam int PW = $clog2(TICK_CYCLES);

  state_t state_reg, state_next;
  logic hook_reg, hook_next;
  logic dial_reg, dial_next;
  logic play_reg, play_next;
  section_t sec_reg, sec_next;
  logic out_reg, out_next;
  logic alt_reg, alt_next;
  logic pound_reg, pound_next;
  logic pass_ok_reg, pass_ok_next;
  logic [2:0] dig_reg, dig_next;
  logic [15:0] shift_reg, shift_next;
  logic [1:0] wrong_reg, wrong_next;
  secs_t win_reg, win_next;
  secs_t inact_reg, inact_next;
  secs_t retry_reg, retry_next;
  logic [PW-1:0] pre_reg;

  // ------------------------------------------------------------
  // Decode
  // ------------------------------------------------------------
  wire tick = (pre_reg == PW'(TICK_CYCLES - 1));
  wire win_exp = tick && (win_reg == 6'h01);
  wire inact_exp = tick && (inact_reg == 6'h01);
  wire is_star = I_KEY_VALID && (I_KEY_CODE == `KEY_STAR);
  wire is_pound = I_KEY_VALID && (I_KEY_CODE == `KEY_POUND);
  wire is_digit = I_KEY_VALID && (I_KEY_CODE < 4'hA);
  wire [15:0] entered = {shift_reg[11:0], I_KEY_CODE};
  wire last_digit = is_digit && (dig_reg == `LAST_DIGIT);
  wire pass_good = last_digit && (entered == I_PASSWORD);
  wire pass_bad = last_digit && (entered != I_PASSWORD);
  wire alarm_on = I_ALARM && !I_ALARM_STOP;
  wire connected = !(state_reg inside {S_IDLE, S_DIAL});
  // Low preset would replay a system prompt, so it is lifted
  wire [6:0] preset = (I_PRESET_SEC < `SEC_USER_MIN) ? `SEC_USER_MIN : I_PRESET_SEC; // RQ1
  wire [6:0] prompt_sec = out_reg ? `SEC_ALARM : `SEC_STATUS;

  function automatic secs_t count_down(input secs_t t, input logic tk);
    count_down = (tk && t != 6'h00) ? t - 6'h01 : t;
  endfunction

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    hook_next = hook_reg;
    dial_next = 1'b0;
    play_next = play_reg;
    sec_next = sec_reg;
    out_next = out_reg;
    alt_next = alt_reg;
    pound_next = pound_reg;
    pass_ok_next = pass_ok_reg;
    dig_next = dig_reg;
    shift_next = shift_reg;
    wrong_next = wrong_reg;
    win_next = count_down(win_reg, tick);
    inact_next = count_down(inact_reg, tick);
    retry_next = count_down(retry_reg, tick);
    if (I_KEY_VALID)
    begin
      inact_next = `INACT_S;
      pound_next = is_pound;
    end
    unique case (state_reg)
      S_IDLE:
      begin
        if (I_RING)
        begin
          hook_next = 1'b1; // RQ6
          out_next = 1'b0;
          play_next = 1'b1;
          sec_next = `SEC_STATUS; // RQ2
          inact_next = `INACT_S;
          state_next = S_PROMPT;
        end
        else if (alarm_on && retry_reg == 6'h00)
        begin
          // Alarm voice with each call attempt, every redial interval
          dial_next = 1'b1; // RQ17
          // Outgoing from the dial on, so the no-answer abort can fire
          out_next = 1'b1;
          play_next = 1'b1; // RQ18
          sec_next = preset;
          win_next = `NOPASS_S;
          state_next = S_DIAL;
        end
      end
      S_DIAL:
      begin
        if (I_ANSWERED)
        begin
          hook_next = 1'b1;
          out_next = 1'b1;
          alt_next = 1'b0;
          play_next = 1'b1;
          sec_next = `SEC_ALARM; // RQ5 RQ8
          win_next = `NOPASS_S;
          inact_next = `INACT_S;
          state_next = S_PROMPT;
        end
      end
      S_PROMPT:
      begin
        if (is_star)
        begin
          play_next = 1'b0; // RQ13
          dig_next = 3'h0;
          win_next = `DIGIT_S; // RQ14
          state_next = S_DIGITS;
        end
        else if (I_PLAY_DONE)
        begin
          // Outgoing prompt alternates alarm section and preset
          alt_next = out_reg && !alt_reg;
          sec_next = (out_reg && !alt_reg) ? preset : prompt_sec; // RQ7 RQ10
          play_next = 1'b1;
        end
      end
      S_DIGITS:
      begin
        if (is_star)
        begin
          dig_next = 3'h0;
          win_next = `DIGIT_S;
        end
        else if (pass_good)
        begin
          pass_ok_next = 1'b1;
          play_next = 1'b1;
          sec_next = `SEC_PASS_OK; // RQ3
          state_next = S_ACK;
        end
        else if (pass_bad)
        begin
          wrong_next = wrong_reg + 2'h1;
          play_next = 1'b1;
          sec_next = `SEC_PASS_BAD; // RQ4
          state_next = S_NAK;
        end
        else if (is_digit)
        begin
          shift_next = entered;
          dig_next = dig_reg + 3'h1;
        end
        else if (win_exp)
        begin
          // Late digits: start over, a fresh star is needed
          alt_next = 1'b0;
          play_next = 1'b1;
          sec_next = prompt_sec; // RQ15
          win_next = out_reg ? `NOPASS_S : 6'h00;
          state_next = S_PROMPT;
        end
      end
      S_NAK:
      begin
        if (I_PLAY_DONE)
        begin
          alt_next = 1'b0;
          sec_next = prompt_sec; // RQ7 RQ10
          win_next = out_reg ? `NOPASS_S : 6'h00;
          state_next = S_PROMPT;
        end
      end
      S_ACK:
      begin
        if (I_PLAY_DONE)
        begin
          play_next = out_reg; // RQ9
          sec_next = preset;
          state_next = S_CTRL;
        end
      end
      S_CTRL:
      begin
        if (is_star)
          play_next = 1'b0; // RQ13
        else if (I_PLAY_DONE && out_reg)
          play_next = 1'b1; // RQ9
      end
      default:
        state_next = S_IDLE;
    endcase
    // Session enders override the per-state work
    // A key on the expiry edge counts as activity, not as silence
    if ((connected && ((inact_exp && !I_KEY_VALID) || (is_pound && pound_reg))) // RQ19 RQ20
        || (state_reg == S_DIGITS && pass_bad && wrong_reg == `WRONG_LIMIT) // RQ16
        || (state_reg inside {S_DIAL, S_PROMPT} && out_reg && win_exp
            && !I_ANSWERED && !is_star)) // RQ11
    begin
      state_next = S_IDLE;
      hook_next = 1'b0;
      play_next = 1'b0;
      pass_ok_next = 1'b0;
      wrong_next = 2'h0;
      pound_next = 1'b0;
      win_next = 6'h00;
      retry_next = `REDIAL_S; // RQ12 RQ17
    end
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge I_CLK)
  begin
    if (I_RST)
    begin
      state_reg <= S_IDLE; // RQ21
      hook_reg <= 1'b0;
      dial_reg <= 1'b0;
      play_reg <= 1'b0;
      sec_reg <= `SEC_STATUS;
      out_reg <= 1'b0;
      alt_reg <= 1'b0;
      pound_reg <= 1'b0;
      pass_ok_reg <= 1'b0;
      dig_reg <= 3'h0;
      shift_reg <= 16'h0000;
      wrong_reg <= 2'h0;
      win_reg <= 6'h00;
      inact_reg <= 6'h00;
      retry_reg <= 6'h00;
      pre_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      hook_reg <= hook_next;
      dial_reg <= dial_next;
      play_reg <= play_next;
      sec_reg <= sec_next;
      out_reg <= out_next;
      alt_reg <= alt_next;
      pound_reg <= pound_next;
      pass_ok_reg <= pass_ok_next;
      dig_reg <= dig_next;
      shift_reg <= shift_next;
      wrong_reg <= wrong_next;
      win_reg <= win_next;
      inact_reg <= inact_next;
      retry_reg <= retry_next;
      pre_reg <= tick ? '0 : pre_reg + 1'b1;
    end
  end

  assign O_OFF_HOOK = hook_reg;
  assign O_DIAL = dial_reg;
  assign O_PLAY = play_reg;
  assign O_SECTION = sec_reg;
  assign O_CTRL_EN = state_reg[6];

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  chk_sec1_needs_pass: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ3
    O_PLAY && O_SECTION == `SEC_PASS_OK |-> pass_ok_reg)
    else $error("section one played without a good password");

  chk_sec0_incoming: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ2
    O_PLAY && O_SECTION == `SEC_STATUS |-> O_OFF_HOOK && !out_reg)
    else $error("status prompt outside an incoming call");

  chk_star_stops: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ13
    state_reg == S_PROMPT && is_star |=> !O_PLAY && state_reg == S_DIGITS)
    else $error("star did not stop playback");

  chk_wrong_plays_two: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ4
    state_reg == S_DIGITS && pass_bad && wrong_reg < `WRONG_LIMIT
    |=> O_PLAY && O_SECTION == `SEC_PASS_BAD)
    else $error("wrong password did not play section two");

  chk_third_wrong: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ16
    state_reg == S_DIGITS && pass_bad && wrong_reg == `WRONG_LIMIT
    |=> !O_OFF_HOOK && !O_PLAY && retry_reg == `REDIAL_S)
    else $error("third wrong password did not hang up");

  chk_pound_twice: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ19
    connected && is_pound && pound_reg |=> !O_OFF_HOOK && state_reg == S_IDLE)
    else $error("double pound did not release the line");

  chk_dial_abort: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ11
    state_reg == S_DIAL && win_exp && !I_ANSWERED |=> state_reg == S_IDLE && !O_PLAY)
    else $error("unanswered call not aborted");

  chk_redial_wait: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ12
    $fell(O_OFF_HOOK) || (state_reg == S_IDLE && $past(state_reg) == S_DIAL)
    |-> retry_reg == `REDIAL_S && !O_DIAL)
    else $error("redial interval not started");

  chk_preset_user: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ1
    O_PLAY && state_reg == S_CTRL |-> O_SECTION >= `SEC_USER_MIN)
    else $error("preset played from a system section");

  chk_reset_idle: assert property (@(posedge I_CLK) disable iff (I_RST) // RQ21
    $past(I_RST) |-> state_reg == S_IDLE && !O_OFF_HOOK && !O_PLAY && retry_reg == 6'h00)
    else $error("reset did not leave the block idle");

endmodule

// ---- voice_call_user.sv ----
// Purpose: Remote caller model that keys tone digits and picks up
// Assumes: Each key is a one-cycle pulse launched after a clock edge
// Notes: The idle key code shows the inverse of the last key
`timescale 1ns/1ps
`include "voice_call_cfg.svh"

module voice_call_user
(
  input wire logic i_clk,
  output logic o_key_valid,
  output voice_call_pkg::key_t o_key_code,
  output logic o_answered
);
  import voice_call_pkg::*;

  initial
  begin
    o_key_valid = 1'b0;
    o_key_code = 4'hF;
    o_answered = 1'b0;
  end

  // Gap gives a slow caller; zero is prompt
  task automatic press(input key_t k, input int gap);
    repeat (gap) @(posedge i_clk);
    @(posedge i_clk);
    o_key_valid <= 1'b1;
    o_key_code <= k;
    @(posedge i_clk);
    o_key_valid <= 1'b0;
    o_key_code <= ~k;
    #1;
  endtask

  // First keyed digit is the top nibble
  task automatic digits(input logic [15:0] pw, input int gap);
    for (int i = 3; i >= 0; i--)
      press(pw[i*4 +: 4], gap);
  endtask

  task automatic star();
    press(`KEY_STAR, 0);
  endtask

  task automatic hang_up(input int gap);
    press(`KEY_POUND, gap);
    press(`KEY_POUND, 0);
  endtask

  task automatic pick_up();
    @(posedge i_clk);
    o_answered <= 1'b1;
    @(posedge i_clk);
    o_answered <= 1'b0;
    #1;
  endtask
endmodule

// ---- tb_phone_voice_call_controller.sv ----
// Purpose: Self-checking bench for the voice call sequencer
// Assumes: One second shortened to T cycles
// Notes: Interval checks allow the one-second timer granularity
`timescale 1ns/1ps
`include "voice_call_cfg.svh"

module tb_phone_voice_call_controller;
  import voice_call_pkg::*;
  localparam int T = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ring_in = 1'b0;
  logic done_in = 1'b0;
  logic alarm = 1'b0;
  logic alarm_stop = 1'b0;
  section_t preset = 7'h05;
  logic key_valid, answered, off_hook, dial, play, ctrl_en;
  key_t key_code;
  section_t section;
  int mismatches = 0;
  int n_tests = 0;
  int c;

  always #12.5 clk = ~clk;

  voice_call_user user (.i_clk(clk), .o_key_valid(key_valid), .o_key_code(key_code),
    .o_answered(answered));

  voice_call_ctrl #(.TICK_CYCLES(T)) dut (.I_CLK(clk), .I_RST(rst), .I_RING(ring_in),
    .I_ANSWERED(answered), .I_KEY_VALID(key_valid), .I_KEY_CODE(key_code),
    .I_PASSWORD(16'h1234), .I_PRESET_SEC(preset), .I_ALARM(alarm),
    .I_ALARM_STOP(alarm_stop), .I_PLAY_DONE(done_in), .O_OFF_HOOK(off_hook), .O_DIAL(dial),
    .O_PLAY(play), .O_SECTION(section), .O_CTRL_EN(ctrl_en));

  // ----------------------------------------
  // Checks and waits
  // ----------------------------------------
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, mismatches);
    if (mismatches == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic fail(input string m);
    mismatches++;
    $display("[FAIL] %0t %s", $time, m);
  endtask

  task automatic chk_bit(input logic g, input logic e, input string m);
    n_tests++;
    if (g !== e)
      fail(m);
  endtask

  task automatic chk_sec(input section_t g, input section_t e, input string m);
    n_tests++;
    if (g !== e)
      fail(m);
  endtask

  task automatic chk_rng(input int g, input int lo, input int hi, input string m);
    n_tests++;
    if (g < lo || g > hi)
      fail(m);
  endtask

  function automatic logic pick(input int w);
    case (w)
      0: return off_hook;
      1: return dial;
      default: return play;
    endcase
  endfunction

  // Counts edges until the output matches; lim means it never did
  task automatic wait_sig(input int w, input logic v, input int lim, input bit must,
    output int n);
    for (n = 0; n < lim; n++)
    begin
      @(posedge clk);
      #1;
      if (pick(w) === v)
        return;
    end
    if (must)
    begin
      fail("wait bound ran out");
      print_verdict();
    end
  endtask

  task automatic pulse(input bit is_ring);
    @(posedge clk);
    if (is_ring)
      ring_in <= 1'b1;
    else
      done_in <= 1'b1;
    @(posedge clk);
    ring_in <= 1'b0;
    done_in <= 1'b0;
    #1;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_reset();
    chk_bit(off_hook, 1'b0, "hook at reset");
    chk_bit(play, 1'b0, "play at reset");
    chk_bit(dial | ctrl_en, 1'b0, "dial or ctrl at reset");
    $display("test reset done");
  endtask

  task automatic t_incoming_ok();
    pulse(1);
    chk_bit(off_hook, 1'b1, "ring not answered");
    chk_sec(section, `SEC_STATUS, "status prompt");
    pulse(0);
    chk_bit(play, 1'b1, "status replay");
    user.star();
    chk_bit(play, 1'b0, "star kept playing");
    user.digits(16'h1234, 2);
    chk_bit(play, 1'b1, "ack silent");
    chk_sec(section, `SEC_PASS_OK, "ack section");
    pulse(0);
    chk_bit(ctrl_en, 1'b1, "no control");
    user.hang_up(1);
    chk_bit(off_hook | ctrl_en, 1'b0, "pound pound kept line");
    $display("test incoming ok done");
  endtask

  task automatic t_wrong();
    pulse(1);
    for (int i = 0; i < 3; i++)
    begin
      user.star();
      user.digits(16'h9999, 0);
      if (i < 2)
      begin
        chk_sec(section, `SEC_PASS_BAD, "nak section");
        chk_bit(play, 1'b1, "nak silent");
        pulse(0);
        chk_sec(section, `SEC_STATUS, "no prompt after nak");
      end
    end
    chk_bit(off_hook | play, 1'b0, "third wrong kept line");
    $display("test wrong password done");
  endtask

  task automatic t_window();
    pulse(1);
    user.star();
    user.press(4'h1, 0);
    user.press(4'h2, 0);
    wait_sig(2, 1'b1, 12*T, 1, c);
    chk_rng(c, 7*T, 9*T+2, "digit window");
    chk_sec(section, `SEC_STATUS, "no prompt replay");
    user.digits(16'h1234, 0);
    chk_sec(section, `SEC_STATUS, "digits taken without star");
    wait_sig(0, 1'b0, 32*T, 1, c);
    chk_rng(c, 29*T-2, 30*T+2, "inactivity hang-up");
    $display("test digit window done");
  endtask

  task automatic t_alarm();
    repeat (21*T) @(posedge clk);
    alarm <= 1'b1;
    preset <= 7'h02;
    wait_sig(1, 1'b1, 4, 1, c);
    chk_sec(section, `SEC_USER_MIN, "preset below four");
    chk_bit(play, 1'b1, "no alarm voice");
    user.pick_up();
    chk_bit(off_hook, 1'b1, "line not seized");
    chk_sec(section, `SEC_ALARM, "alarm prompt");
    pulse(0);
    chk_sec(section, `SEC_USER_MIN, "no preset");
    user.star();
    user.digits(16'h4321, 0);
    chk_sec(section, `SEC_PASS_BAD, "outgoing nak");
    pulse(0);
    chk_sec(section, `SEC_ALARM, "no prompt after nak");
    user.star();
    user.digits(16'h1234, 3);
    chk_sec(section, `SEC_PASS_OK, "outgoing ack");
    pulse(0);
    chk_bit(ctrl_en, 1'b1, "no control");
    pulse(0);
    chk_sec(section, `SEC_USER_MIN, "preset not repeated");
    user.hang_up(0);
    chk_bit(off_hook, 1'b0, "line kept");
    wait_sig(1, 1'b1, 22*T, 1, c);
    chk_rng(c, 19*T-2, 20*T+2, "alarm call interval");
    $display("test alarm call done");
  endtask

  task automatic t_abort();
    wait_sig(2, 1'b0, 42*T, 1, c);
    chk_rng(c, 39*T-2, 40*T+2, "no-answer abort");
    chk_bit(off_hook, 1'b0, "line after abort");
    wait_sig(1, 1'b1, 22*T, 1, c);
    chk_rng(c, 19*T-2, 20*T+2, "redial interval");
    @(posedge clk);
    alarm_stop <= 1'b1;
    wait_sig(1, 1'b1, 25*T, 0, c);
    chk_rng(c, 25*T, 25*T, "stop did not end calls");
    $display("test abort and redial done");
  endtask

  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    #1;
    t_reset();
    t_incoming_ok();
    t_wrong();
    t_window();
    t_alarm();
    t_abort();
    print_verdict();
  end
endmodule
